/* hw/mior_exec.sv */
/*
  execution slice of an 8-bit core: increment, or, copy, rotate left,
  store accumulator, load literal, returns and the idle instruction.
  assumes the decoder offers one word per instruction cycle with
  i_ir_valid, the register file returns the addressed byte combinationally
  on i_file_rd and takes o_file_we as a one-cycle write strobe, and the
  stack presents its top on i_stack_top and pops on o_stack_pop.
  bank selection, stack depth and every other instruction live outside;
  the whole slice runs on i_mclk, with i_rst asynchronous and active high,
  and clearing the irq enable belongs to the interrupt entry logic.
*/
// Notes on behaviour
// - destination bit 0 writes accumulator, 1 writes file register
// - increment adds one to file, result to destination, updates zero
// - or accumulator with file, result to destination, updates zero
// - copy moves file to accumulator or back to same register
// - copy updates zero from moved value, making write-back a zero test
// - copy updates zero whatever destination is chosen
// - load literal puts 8-bit immediate in accumulator, flags untouched
// - store writes accumulator into addressed file, flags untouched
// - return with literal loads immediate into accumulator
// - return with literal reloads pc from popped stack top
// - return with literal takes two instruction cycles
// - rotate left through carry, result to destination, only carry
`timescale 1ns/1ns
`include "mior_defines.svh"

module mior_exec #(
  parameter int PC_W = 13
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  input  wire logic [13:0]       i_ir,
  input  wire logic              i_ir_valid,
  input  wire logic [7:0]        i_file_rd,
  input  wire logic [PC_W-1:0]   i_stack_top,
  output logic      [6:0]        o_file_addr,
  output logic      [7:0]        o_file_wdata,
  output logic                   o_file_we,
  output logic      [7:0]        o_accum,
  output logic                   o_zero,
  output logic                   o_carry,
  output logic                   o_global_irq_enable,
  output logic      [PC_W-1:0]   o_pc,
  output logic                   o_stack_pop,
  output logic                   o_busy
);

  function automatic mior_pkg::mior_kind_t decode(input logic [13:0] w);
    mior_pkg::mior_kind_t k;
    k = mior_pkg::MIOR_OP_NONE_T_IDLE;
    if (w[13:8] == `MIOR_OP_INC_FILE)        k = mior_pkg::MIOR_K_INC;
    else if (w[13:8] == `MIOR_OP_OR_FILE)    k = mior_pkg::MIOR_K_IOR;
    else if (w[13:8] == `MIOR_OP_COPY_FILE)  k = mior_pkg::MIOR_K_MOV;
    else if (w[13:8] == `MIOR_OP_ROT_LEFT)   k = mior_pkg::MIOR_K_ROT;
    else if (w[13:7] == `MIOR_OP_STORE_ACC)  k = mior_pkg::MIOR_K_STORE;
    else if (w[13:10] == `MIOR_OP_LOAD_LIT)  k = mior_pkg::MIOR_K_LIT;
    else if (w[13:10] == `MIOR_OP_RET_LIT)   k = mior_pkg::MIOR_K_RETLIT;
    else if (w == `MIOR_WORD_RET_IRQ)        k = mior_pkg::MIOR_K_RETIRQ;
    return k;
  endfunction

  // operand fields and the zero test, shared by several operations
  function automatic logic [6:0] file_field(input logic [13:0] w);
    return w[`MIOR_FADDR_MSB:0];
  endfunction

  function automatic logic [7:0] lit_field(input logic [13:0] w);
    return w[`MIOR_LIT_MSB:0];
  endfunction

  function automatic logic zero_of(input logic [7:0] v);
    return (v == 8'h00);
  endfunction

  mior_pkg::mior_state_t state_r, state_nxt;
  mior_pkg::mior_kind_t  kind;
  logic [7:0]       acc_r, acc_nxt;
  logic             zero_r, zero_nxt;
  logic             carry_r, carry_nxt;
  logic             irqen_r, irqen_nxt;
  logic [PC_W-1:0]  pc_r, pc_nxt;
  logic [7:0]       fwd_r, fwd_nxt;
  logic [6:0]       fad_r, fad_nxt;
  logic             fwe_r, fwe_nxt;
  logic             pop_r, pop_nxt;
  logic [7:0]       result;
  logic             dest_file;
  logic             has_result;

  assign kind      = decode(i_ir);
  assign dest_file = i_ir[`MIOR_DEST_BIT];

  always_comb begin
    state_nxt  = state_r;
    acc_nxt    = acc_r;
    zero_nxt   = zero_r;
    carry_nxt  = carry_r;
    irqen_nxt  = irqen_r;
    pc_nxt     = pc_r;
    fwd_nxt    = fwd_r;
    fad_nxt    = file_field(i_ir);
    fwe_nxt    = 1'b0;
    pop_nxt    = 1'b0;
    result     = i_file_rd;
    has_result = 1'b0;
    case (state_r)
      mior_pkg::MIOR_S_RUN: begin
        if (i_ir_valid) begin
          // pc advances once per taken word except a return, which loads the stack top; the flush cycle holds it
          pc_nxt = pc_r + PC_W'(1);
          case (kind)
            mior_pkg::MIOR_K_INC: begin
              result     = i_file_rd + 8'h01;
              zero_nxt   = zero_of(result);
              has_result = 1'b1;
            end
            mior_pkg::MIOR_K_IOR: begin
              result     = acc_r | i_file_rd;
              zero_nxt   = zero_of(result);
              has_result = 1'b1;
            end
            mior_pkg::MIOR_K_MOV: begin
              result     = i_file_rd;
              // zero test applies to both destinations
              zero_nxt   = zero_of(result);
              has_result = 1'b1;
            end
            mior_pkg::MIOR_K_ROT: begin
              result     = {i_file_rd[6:0], carry_r};
              carry_nxt  = i_file_rd[7];
              has_result = 1'b1;
            end
            mior_pkg::MIOR_K_STORE: begin
              // the accumulator leaves unchanged, so no flag moves
              fwd_nxt = acc_r;
              fwe_nxt = 1'b1;
            end
            mior_pkg::MIOR_K_LIT: begin
              // literal loads leave zero and carry alone
              acc_nxt = lit_field(i_ir);
            end
            mior_pkg::MIOR_K_RETLIT: begin
              acc_nxt   = lit_field(i_ir);
              pc_nxt    = i_stack_top;
              pop_nxt   = 1'b1;
              state_nxt = mior_pkg::MIOR_S_FLUSH;
            end
            mior_pkg::MIOR_K_RETIRQ: begin
              // a pop with no literal: the accumulator is left as it was
              pc_nxt    = i_stack_top;
              pop_nxt   = 1'b1;
              irqen_nxt = 1'b1;
              state_nxt = mior_pkg::MIOR_S_FLUSH;
            end
            default: begin
              // idle and unhandled words only advance the pc
              pc_nxt = pc_r + PC_W'(1);
            end
          endcase
          // one write path for every result keeps the select in one place
          if (has_result) begin
            if (dest_file) begin
              fwd_nxt = result;
              fwe_nxt = 1'b1;
            end else begin
              acc_nxt = result;
            end
          end
        end
      end
      mior_pkg::MIOR_S_FLUSH: begin
        // second cycle of a return: fetched word is discarded
        state_nxt = mior_pkg::MIOR_S_RUN;
      end
      default: state_nxt = mior_pkg::MIOR_S_RUN;
    endcase
  end

  // registers only; every next value is formed in the block above
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= mior_pkg::MIOR_S_RUN;
      acc_r   <= `MIOR_ACC_RST;
      zero_r  <= 1'b0;
      carry_r <= 1'b0;
      irqen_r <= 1'b0;
      pc_r    <= PC_W'(`MIOR_PC_RST);
      fwd_r   <= 8'h00;
      fad_r   <= 7'h00;
      fwe_r   <= 1'b0;
      pop_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      acc_r   <= acc_nxt;
      zero_r  <= zero_nxt;
      carry_r <= carry_nxt;
      irqen_r <= irqen_nxt;
      pc_r    <= pc_nxt;
      fwd_r   <= fwd_nxt;
      fad_r   <= fad_nxt;
      fwe_r   <= fwe_nxt;
      pop_r   <= pop_nxt;
    end
  end

  // read address is combinational so the operand arrives in the same cycle;
  // a pending write owns the address for its one cycle, so the decoder must
  // not read any file register in the cycle right after, as the read address is then fad_r
  assign o_file_addr         = fwe_r ? fad_r : file_field(i_ir);
  assign o_file_wdata        = fwd_r;
  assign o_file_we           = fwe_r;
  assign o_accum             = acc_r;
  assign o_zero              = zero_r;
  assign o_carry             = carry_r;
  assign o_global_irq_enable = irqen_r;
  assign o_pc                = pc_r;
  assign o_stack_pop         = pop_r;
  assign o_busy              = (state_r == mior_pkg::MIOR_S_FLUSH);

endmodule

/* hw/mior_defines.svh */
/*
  constants for the move/inc/or/return execution slice: opcode patterns,
  field positions and reset values. assumes 14-bit instruction words.
*/
`ifndef MIOR_DEFINES_SVH
`define MIOR_DEFINES_SVH

`define MIOR_IW             14
`define MIOR_DEST_BIT       7
`define MIOR_FADDR_MSB      6
`define MIOR_LIT_MSB        7
// byte-oriented file ops: bits 13:8
`define MIOR_OP_INC_FILE    6'h0a
`define MIOR_OP_OR_FILE     6'h04
`define MIOR_OP_COPY_FILE   6'h08
`define MIOR_OP_ROT_LEFT    6'h0d
// store accumulator: bits 13:7
`define MIOR_OP_STORE_ACC   7'h01
// literal ops: bits 13:10
`define MIOR_OP_LOAD_LIT    4'hc
`define MIOR_OP_RET_LIT     4'hd
`define MIOR_WORD_IDLE      14'h0000
`define MIOR_WORD_RET_IRQ   14'h0009
`define MIOR_ACC_RST        8'h00
`define MIOR_PC_RST         13'h0000

`endif

/* hw/mior_pkg.sv */
/*
  types for the execution slice: decoded operation classes and the
  sequencer states. assumes mior_defines.svh supplies the numbers.
*/
package mior_pkg;
  typedef enum logic [8:0] {
    MIOR_OP_NONE_T_IDLE = 9'h001,
    MIOR_K_INC          = 9'h002,
    MIOR_K_IOR          = 9'h004,
    MIOR_K_MOV          = 9'h008,
    MIOR_K_ROT          = 9'h010,
    MIOR_K_STORE        = 9'h020,
    MIOR_K_LIT          = 9'h040,
    MIOR_K_RETLIT       = 9'h080,
    MIOR_K_RETIRQ       = 9'h100
  } mior_kind_t;

  typedef enum logic [1:0] {
    MIOR_S_RUN   = 2'h1,
    MIOR_S_FLUSH = 2'h2
  } mior_state_t;
endpackage

/* dv/mior_exec_checker.sv */
/* checker: opcode effects seen at the ports of mior_exec
   assumes it is bound to every mior_exec instance */
`timescale 1ns/1ns
module mior_exec_checker #(parameter int PC_W = 13) (
  input wire logic            i_mclk,
  input wire logic            i_rst,
  input wire logic [13:0]     i_ir,
  input wire logic            i_ir_valid,
  input wire logic [7:0]      i_file_rd,
  input wire logic [PC_W-1:0] i_stack_top,
  input wire logic [6:0]      o_file_addr,
  input wire logic [7:0]      o_file_wdata,
  input wire logic            o_file_we,
  input wire logic [7:0]      o_accum,
  input wire logic            o_zero,
  input wire logic            o_carry,
  input wire logic            o_global_irq_enable,
  input wire logic [PC_W-1:0] o_pc,
  input wire logic            o_stack_pop,
  input wire logic            o_busy
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  wire logic       tk = i_ir_valid & ~o_busy;
  wire logic [5:0] op = i_ir[13:8];
  // both returns pop once and then spend one dead cycle
  sequence flush_s;
    o_busy && o_stack_pop && o_pc == $past(i_stack_top)
    ##1 !o_busy && !o_stack_pop;
  endsequence
  lit_load_a: assert property (tk && i_ir[13:10] == 4'hc |=>
    o_accum == $past(i_ir[7:0]) && $stable({o_zero, o_carry}))
    else $error("load literal wrong");
  inc_back_a: assert property (tk && op == 6'h0a && i_ir[7] |=>
    o_file_we && o_file_addr == $past(i_ir[6:0])
    && o_file_wdata == $past(i_file_rd) + 8'h01
    && o_zero == !o_file_wdata) else $error("increment wrong");
  or_accum_a: assert property (tk && op == 6'h04 && !i_ir[7] |=>
    !o_file_we && o_accum == ($past(o_accum) | $past(i_file_rd))
    && o_zero == !o_accum) else $error("or wrong");
  copy_zero_a: assert property (tk && op == 6'h08 |=>
    o_zero == !$past(i_file_rd)) else $error("copy zero wrong");
  store_acc_a: assert property (tk && i_ir[13:7] == 7'h01 |=>
    o_file_we && o_file_addr == $past(i_ir[6:0])
    && o_file_wdata == $past(o_accum) && $stable(o_zero))
    else $error("store wrong");
  rot_carry_a: assert property (tk && op == 6'h0d && !i_ir[7] |=>
    o_accum == {$past(i_file_rd[6:0]), $past(o_carry)}
    && o_carry == $past(i_file_rd[7]) && $stable(o_zero))
    else $error("rotate wrong");
  ret_lit_a: assert property (tk && i_ir[13:10] == 4'hd |=>
    o_accum == $past(i_ir[7:0]) ##0 flush_s) else $error("retlit wrong");
  ret_irq_a: assert property (tk && i_ir == 14'h0009 |=>
    o_global_irq_enable ##0 flush_s) else $error("retirq wrong");
  idle_pc_a: assert property (tk && i_ir == 14'h0000 |=>
    o_pc == $past(o_pc) + 1'b1 && $stable(o_accum) && !o_file_we)
    else $error("idle wrong");
endmodule
bind mior_exec mior_exec_checker #(.PC_W(PC_W)) chk_i (
  .i_mclk              (i_mclk),
  .i_rst               (i_rst),
  .i_ir                (i_ir),
  .i_ir_valid          (i_ir_valid),
  .i_file_rd           (i_file_rd),
  .i_stack_top         (i_stack_top),
  .o_file_addr         (o_file_addr),
  .o_file_wdata        (o_file_wdata),
  .o_file_we           (o_file_we),
  .o_accum             (o_accum),
  .o_zero              (o_zero),
  .o_carry             (o_carry),
  .o_global_irq_enable (o_global_irq_enable),
  .o_pc                (o_pc),
  .o_stack_pop         (o_stack_pop),
  .o_busy              (o_busy)
);

/* dv/tb_mcu_move_inc_or_return_ops.sv */
/* bench for mior_exec: one task per group of opcodes
   assumes the checker file binds itself to the design */
`timescale 1ns/1ns
module tb_mcu_move_inc_or_return_ops;
  logic        i_mclk, i_rst, i_ir_valid, o_file_we, o_zero, o_carry;
  logic        o_global_irq_enable, o_stack_pop, o_busy;
  logic [13:0] i_ir;
  logic [7:0]  i_file_rd, o_file_wdata, o_accum;
  logic [12:0] i_stack_top, o_pc;
  logic [6:0]  o_file_addr;
  int          mismatches = 0, comparisons = 0, cycles = 0;
  mior_exec uut (.i_mclk, .i_rst, .i_ir, .i_ir_valid, .i_file_rd,
    .i_stack_top, .o_file_addr, .o_file_wdata, .o_file_we, .o_accum,
    .o_zero, .o_carry, .o_global_irq_enable, .o_pc, .o_stack_pop, .o_busy);
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 200) begin
      mismatches++;
      test_done();
    end
  end
  // flags f: we, zero, carry, irq enable, pop, busy; wdata only under we
  task automatic chk(string n, logic [12:0] p, logic [7:0] a, w,
                     logic [5:0] f);
    logic [34:0] g;
    g = {o_pc, o_accum, o_file_we ? o_file_wdata : 8'h00, o_file_we,
         o_zero, o_carry, o_global_irq_enable, o_stack_pop, o_busy};
    comparisons++;
    if (g !== {p, a, w, f}) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, {p, a, w, f}, g);
    end
  endtask
  // a word is offered at one edge and taken at the next; judged at the fall
  task automatic run(logic [13:0] w, logic [7:0] rd);
    @(posedge i_mclk);
    i_ir       <= w;
    i_file_rd  <= rd;
    i_ir_valid <= 1'b1;
    @(posedge i_mclk);
    i_ir_valid <= 1'b0;
    @(negedge i_mclk);
  endtask
  // a return, then a load offered at once, which lands in the flush cycle
  task automatic ret_pair(logic [13:0] w, logic [12:0] top);
    @(posedge i_mclk);
    i_ir        <= w;
    i_stack_top <= top;
    i_ir_valid  <= 1'b1;
    @(posedge i_mclk);
    i_ir        <= 14'h3011;
    @(negedge i_mclk);
  endtask
  task automatic settle();
    @(posedge i_mclk);
    i_ir_valid <= 1'b0;
    @(negedge i_mclk);
  endtask
  task automatic t_lit_store();
    run(14'h30ff, 8'h00);
    chk("load", 13'h001, 8'hff, 8'h00, 6'h00);
    run(14'h0095, 8'h3c);
    chk("store", 13'h002, 8'hff, 8'hff, 6'h20);
  endtask
  task automatic t_inc();
    run(14'h0a10, 8'hff);
    chk("inc acc", 13'h003, 8'h00, 8'h00, 6'h10);
    run(14'h0a90, 8'h7f);
    chk("inc file", 13'h004, 8'h00, 8'h80, 6'h20);
  endtask
  task automatic t_or();
    run(14'h0410, 8'h00);
    chk("or acc", 13'h005, 8'h00, 8'h00, 6'h10);
    run(14'h04a0, 8'h0c);
    chk("or file", 13'h006, 8'h00, 8'h0c, 6'h20);
  endtask
  task automatic t_copy();
    run(14'h08c5, 8'h00);
    chk("copy test", 13'h007, 8'h00, 8'h00, 6'h30);
    run(14'h0845, 8'h80);
    chk("copy acc", 13'h008, 8'h80, 8'h00, 6'h00);
  endtask
  task automatic t_rot();
    run(14'h0d10, 8'h80);
    chk("rot acc", 13'h009, 8'h00, 8'h00, 6'h08);
    run(14'h0d90, 8'h40);
    chk("rot file", 13'h00a, 8'h00, 8'h81, 6'h20);
  endtask
  task automatic t_ret();
    ret_pair(14'h345a, 13'h1abc);
    chk("retlit", 13'h1abc, 8'h5a, 8'h00, 6'h03);
    settle();
    chk("flush", 13'h1abc, 8'h5a, 8'h00, 6'h00);
    ret_pair(14'h0009, 13'h0123);
    chk("retirq", 13'h0123, 8'h5a, 8'h00, 6'h07);
    settle();
    chk("irq flush", 13'h0123, 8'h5a, 8'h00, 6'h04);
  endtask
  task automatic t_idle();
    run(14'h0000, 8'h00);
    chk("idle", 13'h0124, 8'h5a, 8'h00, 6'h04);
  endtask
  initial begin
    i_rst = 1'b1;
    i_ir = 14'h0000;
    i_ir_valid = 1'b0;
    i_file_rd = 8'h00;
    i_stack_top = 13'h0000;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_lit_store();
    t_inc();
    t_or();
    t_copy();
    t_rot();
    t_ret();
    t_idle();
    test_done();
  end
endmodule
